// *** src/wetting_current_map.vh ***
// Register offsets, field positions, reset values and current codes for the wetting-current block.
`ifndef WETTING_CURRENT_MAP_VH
`define WETTING_CURRENT_MAP_VH
`define WC_ADDR_W           6
`define WC_DATA_W           24
`define WC_CFG_LO_ADDR      6'h1D
`define WC_CFG_HI_ADDR      6'h1E
`define WC_CFG_RESET        24'h000000
`define WC_CFG_HI_WMASK     24'h7FFFFF
`define WC_CFG_LO_WMASK     24'hFFFFFF
`define WC_PAIR_0_1_LSB     0
`define WC_PAIR_2_3_LSB     3
`define WC_PAIR_20_21_LSB   12
`define WC_INPUT_22_LSB     15
`define WC_INPUT_23_LSB     18
`define WC_SOURCE_OFF_BIT   21
`define WC_SINK_OFF_BIT     22
`define WC_LEVEL_W          3
`define WC_LEVEL_NONE       3'h0
`define WC_LEVEL_1MA        3'h1
`define WC_LEVEL_2MA        3'h2
`define WC_LEVEL_5MA        3'h3
`define WC_LEVEL_10MA       3'h4
`define WC_LEVEL_15MA       3'h5
`endif

// *** src/wetting_current_cfg.v ***
// Wetting-current configuration registers with per-input current level decode and auto-scaling.
`timescale 1ns/10ps
`include "wetting_current_map.vh"

// Overview of operation
// [RL1] The second configuration register sits at offset 0x1E and resets to all zeros.
// [RL2] Codes 0, 1, 2 and 3 select no current, 1mA, 2mA and 5mA respectively.
// [RL3] Code 4 selects 10mA and every code from 5 through 7 selects 15mA.
// [RL4] In the first register bits 5-3 hold the code for inputs 2 and 3 and bits 2-0 the code for inputs 0 and 1.
// [RL5] In the second register bits 20-18, 17-15 and 14-12 hold the codes for input 23, input 22 and inputs 20-21.
// [RL6] Bit 22 at zero lets sink inputs at 10mA or 15mA drop to 2mA on closure in continuous mode.
// [RL7] Bit 21 at zero lets source inputs at 10mA or 15mA drop to 2mA on closure in continuous mode.
// [RL8] Bits 23 and above of the second register read zero and ignore writes.
// [RL9] A direction bit for inputs 0 to 9 selects source at zero and sink at one.
// [RL10] Both inputs of a shared-code pair receive the same setting decoded from that one code.
module wetting_current_cfg (
  // Clock and reset.
  input  wire        CLK_IN,
  input  wire        SRST_IN,
  // Register access from the serial interface.
  input  wire        REG_WR_IN,
  input  wire [5:0]  REG_ADDR_IN,
  input  wire [23:0] REG_WDATA_IN,
  output reg  [23:0] REG_RDATA_OUT,
  // Operating state.
  input  wire        CONTINUOUS_MODE_IN,
  input  wire [9:0]  CURRENT_SINK_SEL_IN,
  input  wire [23:0] SWITCH_CLOSED_IN,
  // Effective level for inputs 0-3 and 20-23, three bits each, low input first.
  output reg  [23:0] WET_LEVEL_OUT
);

  reg  [23:0] wetting_current_cfg_lo;
  reg  [23:0] wetting_current_cfg_hi;
  reg  [9:0]  sink_sync1;
  reg  [9:0]  sink_sync2;
  reg  [9:0]  sink_sync3;
  reg  [9:0]  current_sink;
  reg  [23:0] next_level;
  reg  [2:0]  level_in0;
  reg  [2:0]  level_in1;
  reg  [2:0]  level_in2;
  reg  [2:0]  level_in3;
  reg  [2:0]  level_in20;
  reg  [2:0]  level_in21;
  reg  [2:0]  level_in22;
  reg  [2:0]  level_in23;
  wire [2:0]  wet_code_pair_0_1;
  wire [2:0]  wet_code_pair_2_3;
  wire [2:0]  wet_code_pair_20_21;
  wire [2:0]  wet_code_input_22;
  wire [2:0]  wet_code_input_23;
  wire        sink_downscale_off;
  wire        source_downscale_off;
  integer     i;

  // Maps a raw field code onto the six distinct current levels.
  function [2:0] decode_level;
    input [2:0] code;
    begin
      case (code)
        3'h0: decode_level = `WC_LEVEL_NONE;   // [RL2]
        3'h1: decode_level = `WC_LEVEL_1MA;    // [RL2]
        3'h2: decode_level = `WC_LEVEL_2MA;    // [RL2]
        3'h3: decode_level = `WC_LEVEL_5MA;    // [RL2]
        3'h4: decode_level = `WC_LEVEL_10MA;   // [RL3]
        default: decode_level = `WC_LEVEL_15MA; // [RL3]
      endcase
    end
  endfunction

  // Applies the closure downscale when the matching disable bit is clear.
  function [2:0] scale_level;
    input [2:0] level;
    input       closed;
    input       off;
    input       cont;
    begin
      if (cont && closed && !off && (level == `WC_LEVEL_10MA || level == `WC_LEVEL_15MA)) begin
        scale_level = `WC_LEVEL_2MA;
      end else begin
        scale_level = level;
      end
    end
  endfunction

  // Compares the bus offset with one register offset; shared by the write and read paths.
  function addr_hit;
    input [5:0] addr;
    input [5:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  // Chooses which disable bit governs an input from its filtered direction.
  function pick_off;
    input sink;
    input sink_off;
    input source_off;
    begin
      if (sink) begin
        pick_off = sink_off;
      end else begin
        pick_off = source_off;
      end
    end
  endfunction

  // Field extraction from the stored register images.
  assign wet_code_pair_0_1    = wetting_current_cfg_lo[`WC_PAIR_0_1_LSB +: `WC_LEVEL_W];   // [RL4]
  assign wet_code_pair_2_3    = wetting_current_cfg_lo[`WC_PAIR_2_3_LSB +: `WC_LEVEL_W];   // [RL4]
  assign wet_code_pair_20_21  = wetting_current_cfg_hi[`WC_PAIR_20_21_LSB +: `WC_LEVEL_W]; // [RL5]
  assign wet_code_input_22    = wetting_current_cfg_hi[`WC_INPUT_22_LSB +: `WC_LEVEL_W];   // [RL5]
  assign wet_code_input_23    = wetting_current_cfg_hi[`WC_INPUT_23_LSB +: `WC_LEVEL_W];   // [RL5]
  assign sink_downscale_off   = wetting_current_cfg_hi[`WC_SINK_OFF_BIT];                 // [RL6]
  assign source_downscale_off = wetting_current_cfg_hi[`WC_SOURCE_OFF_BIT];               // [RL7]

  // Register writes; reserved bits are masked so they can never be set.
  always @(posedge CLK_IN) begin
    if (SRST_IN) begin
      wetting_current_cfg_lo <= `WC_CFG_RESET;
      wetting_current_cfg_hi <= `WC_CFG_RESET; // [RL1]
    end else if (REG_WR_IN) begin
      if (addr_hit(REG_ADDR_IN, `WC_CFG_LO_ADDR)) begin
        wetting_current_cfg_lo <= REG_WDATA_IN & `WC_CFG_LO_WMASK; // [RL4]
      end
      if (addr_hit(REG_ADDR_IN, `WC_CFG_HI_ADDR)) begin
        wetting_current_cfg_hi <= REG_WDATA_IN & `WC_CFG_HI_WMASK; // [RL1] [RL5] [RL8]
      end
    end
  end

  // Read data is registered; unmapped offsets read zero.
  always @(posedge CLK_IN) begin
    if (SRST_IN) begin
      REG_RDATA_OUT <= 24'h000000;
    end else if (addr_hit(REG_ADDR_IN, `WC_CFG_LO_ADDR)) begin
      REG_RDATA_OUT <= wetting_current_cfg_lo;
    end else if (addr_hit(REG_ADDR_IN, `WC_CFG_HI_ADDR)) begin
      REG_RDATA_OUT <= wetting_current_cfg_hi & `WC_CFG_HI_WMASK; // [RL8]
    end else begin
      REG_RDATA_OUT <= 24'h000000;
    end
  end

  // The direction selects come from another register block, possibly another clock, so they are filtered.
  always @(posedge CLK_IN) begin
    if (SRST_IN) begin
      sink_sync1   <= 10'h000;
      sink_sync2   <= 10'h000;
      sink_sync3   <= 10'h000;
      current_sink <= 10'h000;
    end else begin
      sink_sync1 <= CURRENT_SINK_SEL_IN;
      sink_sync2 <= sink_sync1;
      sink_sync3 <= sink_sync2;
      for (i = 0; i < 10; i = i + 1) begin
        if (sink_sync2[i] == sink_sync3[i]) begin
          current_sink[i] <= sink_sync3[i]; // [RL9]
        end
      end
    end
  end

  // Inputs 20-23 have no direction select and are treated as sources.
  always @* begin
    level_in0 = scale_level(
      decode_level(wet_code_pair_0_1),                                     // [RL4] [RL10]
      SWITCH_CLOSED_IN[0],
      pick_off(current_sink[0], sink_downscale_off, source_downscale_off), // [RL6] [RL7] [RL9]
      CONTINUOUS_MODE_IN);

    level_in1 = scale_level(
      decode_level(wet_code_pair_0_1),                                     // [RL4] [RL10]
      SWITCH_CLOSED_IN[1],
      pick_off(current_sink[1], sink_downscale_off, source_downscale_off), // [RL6] [RL7] [RL9]
      CONTINUOUS_MODE_IN);

    level_in2 = scale_level(
      decode_level(wet_code_pair_2_3),                                     // [RL4] [RL10]
      SWITCH_CLOSED_IN[2],
      pick_off(current_sink[2], sink_downscale_off, source_downscale_off), // [RL6] [RL7] [RL9]
      CONTINUOUS_MODE_IN);

    level_in3 = scale_level(
      decode_level(wet_code_pair_2_3),                                     // [RL4] [RL10]
      SWITCH_CLOSED_IN[3],
      pick_off(current_sink[3], sink_downscale_off, source_downscale_off), // [RL6] [RL7] [RL9]
      CONTINUOUS_MODE_IN);

    level_in20 = scale_level(
      decode_level(wet_code_pair_20_21),                                   // [RL5] [RL10]
      SWITCH_CLOSED_IN[20],
      pick_off(1'b0, sink_downscale_off, source_downscale_off),            // [RL7]
      CONTINUOUS_MODE_IN);

    level_in21 = scale_level(
      decode_level(wet_code_pair_20_21),                                   // [RL5] [RL10]
      SWITCH_CLOSED_IN[21],
      pick_off(1'b0, sink_downscale_off, source_downscale_off),            // [RL7]
      CONTINUOUS_MODE_IN);

    level_in22 = scale_level(
      decode_level(wet_code_input_22),                                     // [RL5]
      SWITCH_CLOSED_IN[22],
      pick_off(1'b0, sink_downscale_off, source_downscale_off),            // [RL7]
      CONTINUOUS_MODE_IN);

    level_in23 = scale_level(
      decode_level(wet_code_input_23),                                     // [RL5]
      SWITCH_CLOSED_IN[23],
      pick_off(1'b0, sink_downscale_off, source_downscale_off),            // [RL7]
      CONTINUOUS_MODE_IN);

    next_level = {level_in23, level_in22, level_in21, level_in20,
                  level_in3, level_in2, level_in1, level_in0};
  end

  always @(posedge CLK_IN) begin
    if (SRST_IN) begin
      WET_LEVEL_OUT <= 24'h000000;
    end else begin
      WET_LEVEL_OUT <= next_level;
    end
  end

endmodule

// *** tb/wc_sva.sv ***
// Port assertions for the wetting-current registers.
`timescale 1ns/10ps
module wc_sva (
  input wire        CLK_IN,
  input wire        SRST_IN,
  input wire        REG_WR_IN,
  input wire [5:0]  REG_ADDR_IN,
  input wire [23:0] REG_RDATA_OUT,
  input wire        CONTINUOUS_MODE_IN,
  input wire [9:0]  CURRENT_SINK_SEL_IN,
  input wire [23:0] SWITCH_CLOSED_IN,
  input wire [23:0] WET_LEVEL_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);
  wire [23:0] r  = REG_RDATA_OUT;
  wire        hi = REG_ADDR_IN == 6'h1E && !REG_WR_IN;
  wire        lo = REG_ADDR_IN == 6'h1D && !REG_WR_IN;
  function automatic [2:0] v(input [2:0] c);
    v = c > 3'h5 ? 3'h5 : c;
  endfunction
  // The register must sit still for four cycles so read data and levels show the same contents.
  property p_dhi; (hi && !CONTINUOUS_MODE_IN)[*4] |=>
    WET_LEVEL_OUT[23:12] == {v(r[20:18]), v(r[17:15]), {2{v(r[14:12])}}}; endproperty
  a_dhi: assert property (p_dhi) else $error("decode");
  property p_scl; (hi && CONTINUOUS_MODE_IN && SWITCH_CLOSED_IN[20])[*4] |=>
    WET_LEVEL_OUT[14:12] == (r[14:12] > 3'h3 && !r[21] ? 3'h2 : v(r[14:12])); endproperty
  a_scl: assert property (p_scl) else $error("scale");
  property p_dlo; (lo && !CONTINUOUS_MODE_IN)[*4] |=>
    WET_LEVEL_OUT[11:0] == {{2{v(r[5:3])}}, {2{v(r[2:0])}}}; endproperty
  a_dlo: assert property (p_dlo) else $error("decode low");
  property p_rst; disable iff (1'b0) SRST_IN |=> r == 24'h000000 && WET_LEVEL_OUT == 24'h000000; endproperty
  a_rst: assert property (p_rst) else $error("reset");
  property p_rsv; REG_ADDR_IN == 6'h1E |=> !r[23]; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved");
  property p_snk; (hi && CONTINUOUS_MODE_IN && SWITCH_CLOSED_IN[0] && CURRENT_SINK_SEL_IN[0])[*6] |=>
    r[22] || WET_LEVEL_OUT[2:0] < 3'h4; endproperty
  a_snk: assert property (p_snk) else $error("sink scale");
  property p_src; (hi && CONTINUOUS_MODE_IN && SWITCH_CLOSED_IN[0] && !CURRENT_SINK_SEL_IN[0])[*6] |=>
    r[21] || WET_LEVEL_OUT[2:0] < 3'h4; endproperty
  a_src: assert property (p_src) else $error("source scale");
endmodule
bind wetting_current_cfg wc_sva wc_sva_inst (.*);

// *** tb/host_model.sv ***
// Host model that writes registers and selects the read address.
`timescale 1ns/10ps
module host_model (
  input  wire        clk_in,
  output reg  [30:0] bus_out = 31'h00000000
);
  task put(input w, input [5:0] a, input [23:0] d);
    @(negedge clk_in);
    bus_out = {w, a, d};
    @(negedge clk_in);
    bus_out[30] = 1'b0;
  endtask
endmodule

// *** tb/wetting_current_cfg_tb_top.sv ***
// Testbench for the wetting-current configuration registers.
`timescale 1ns/10ps
module wetting_current_cfg_tb_top;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg         cont = 1'b0;
  reg  [33:0] sw = 34'h000000000;
  wire [30:0] bus;
  wire [23:0] rd;
  wire [23:0] lv;
  integer     mismatches = 0;
  integer     n_checks = 0;
  reg  [95:0] row [0:2];
  always #2 clk = ~clk;
  host_model host_inst (.clk_in(clk), .bus_out(bus));
  wetting_current_cfg wetting_current_cfg_inst (.CLK_IN(clk), .SRST_IN(rst), .REG_WR_IN(bus[30]),
    .REG_ADDR_IN(bus[29:24]), .REG_WDATA_IN(bus[23:0]), .REG_RDATA_OUT(rd), .CONTINUOUS_MODE_IN(cont),
    .CURRENT_SINK_SEL_IN(sw[33:24]), .SWITCH_CLOSED_IN(sw[23:0]), .WET_LEVEL_OUT(lv));
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Waits long enough for the direction filter and level register to settle.
  task wr(input [5:0] a, input [23:0] d, input [23:0] e, input [23:0] el);
    host_inst.put(1'b1, a, d);
    rd_chk(a, e, el);
  endtask
  task rd_chk(input [5:0] a, input [23:0] e, input [23:0] el);
    host_inst.put(1'b0, a, 24'h000000);
    repeat (4) @(negedge clk);
    n_checks = n_checks + 1;
    if (rd !== e || lv !== el) begin
      mismatches = mismatches + 1;
      $display("Error rd/lv expected %h/%h seen %h/%h", e, el, rd, lv);
    end
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    mismatches = mismatches + 1;
    report_and_stop;
  end
  initial begin
    row[0] = {24'h000008, 24'hFFFFFF, 24'h7FFFFF, 24'hB6D240};
    row[1] = {24'h000013, 24'h1A2000, 24'h1A2000, 24'hB1249B};
    row[2] = {24'h000024, 24'h14B000, 24'h14B000, 24'hA5B924};
    repeat (20) @(negedge clk);
    rst = 1'b0;
    wr(6'h3F, 24'hFFFFFF, 24'h000000, 24'h000000);
    for (int i = 0; i < 3; i = i + 1) begin
      host_inst.put(1'b1, 6'h1D, row[i][95:72]);
      wr(6'h1E, row[i][71:48], row[i][47:24], row[i][23:0]);
      rd_chk(6'h1D, row[i][95:72], row[i][23:0]);
    end
    cont = 1'b1;
    sw = {10'h001, 24'h100001};
    host_inst.put(1'b1, 6'h1D, 24'h000005);
    wr(6'h1E, 24'h004000, 24'h004000, 24'h02202A);
    wr(6'h1E, 24'h604000, 24'h604000, 24'h02402D);
    wr(6'h1E, 24'h204000, 24'h204000, 24'h02402A);
    wr(6'h1E, 24'h404000, 24'h404000, 24'h02202D);
    sw = {10'h000, 24'h100001};
    wr(6'h1E, 24'h404000, 24'h404000, 24'h02202A);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    n_checks = n_checks + 1;
    if (rd !== 24'h000000 || lv !== 24'h000000) begin
      mismatches = mismatches + 1;
      $display("Error reset rd/lv expected 000000/000000 seen %h/%h", rd, lv);
    end
    rst = 1'b0;
    rd_chk(6'h1E, 24'h000000, 24'h000000);
    rd_chk(6'h1D, 24'h000000, 24'h000000);
    report_and_stop;
  end
endmodule
